// ==== rrs_port.sv ====
// Run-synchronization port: shared open-drain lines and start contact closure
`default_nettype none
// Function
// - Lines are wired-AND; only pull low, never drive high.
// - Outside prepare low puts the device into its preparation state.
// - Ready released high only while the whole system is ready; else low.
// - Start low begins the run; device drives start low when starting itself.
// - Outside start must stay low 500 us; shorter pulses are ignored.
// - On run start close the isolated contact for 120 ms, then open it; the port opens it at once if the run ends sooner.
// - Stop low ends the run at once and returns to ready.
module rrs_port #(
    parameter int unsigned RELAY_CYC = rrs_pkg::RELAY_CYC_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic prepare_in,
    input wire logic start_in,
    input wire logic ready_in,
    input wire logic stop_in,
    input wire rrs_pkg::rrs_core_req_t core_req,
    output rrs_pkg::rrs_pins_out_t pins,
    output rrs_pkg::rrs_core_ind_t ind
);
    import rrs_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic prep_s;
    logic start_s;
    logic stop_s;

    rrs_sync u_sync_prep (.clk(clk), .rst(rst), .d(prepare_in), .q(prep_s));
    rrs_sync u_sync_start (.clk(clk), .rst(rst), .d(start_in), .q(start_s));
    rrs_sync u_sync_stop (.clk(clk), .rst(rst), .d(stop_in), .q(stop_s));

    // Ready is sensed only by controllers; the port need not read it back
    logic ready_unused;
    assign ready_unused = ready_in;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        rrs_mode_t mode;
        logic [CNT_W-1:0] start_cnt;
        logic start_seen;
        logic [CNT_W-1:0] drive_cnt;
        logic [CNT_W-1:0] relay_cnt;
        logic relay;
        logic prep_evt;
        logic start_evt;
        logic stop_evt;
        logic [CNT_W-1:0] low_run;
    } rrs_state_t;

    rrs_state_t state;
    rrs_state_t next_state;
    logic ext_start;
    logic own_start;
    logic go;

    always_comb begin
        next_state = state;
        next_state.prep_evt = 1'b0;
        next_state.start_evt = 1'b0;
        next_state.stop_evt = 1'b0;
        ext_start = 1'b0;
        // Width counter saturates so a held line counts once
        if (!start_s && state.drive_cnt == '0) begin
            if (state.start_cnt != CNT_W'(START_MIN_CYC)) begin
                next_state.start_cnt = state.start_cnt + 1'b1;
            end
            if (state.start_cnt == CNT_W'(START_MIN_CYC - 1) && !state.start_seen) begin
                ext_start = 1'b1;
                next_state.start_seen = 1'b1;
            end
        end else if (start_s) begin
            next_state.start_cnt = '0;
            next_state.start_seen = 1'b0;
        end
        // Checker-only length of the present low run; unlike the width
        // counter it keeps counting while the port drives start, so it bounds every accepted start
        if (start_s) begin
            next_state.low_run = '0;
        end else if (state.low_run != '1) begin
            next_state.low_run = state.low_run + 1'b1;
        end
        own_start = core_req.local_start && state.mode != RRS_RUN;
        go = (ext_start && state.mode != RRS_RUN) || own_start;
        if (state.drive_cnt != '0) begin
            next_state.drive_cnt = state.drive_cnt - 1'b1;
        end
        if (state.relay_cnt != '0) begin
            next_state.relay_cnt = state.relay_cnt - 1'b1;
        end else begin
            next_state.relay = 1'b0;
        end
        case (state.mode)
            RRS_IDLE: begin
                if (!prep_s || core_req.local_prepare) begin
                    next_state.mode = RRS_PREP;
                    next_state.prep_evt = 1'b1;
                end
            end
            RRS_PREP: begin
                if (!stop_s || core_req.local_stop) begin
                    next_state.mode = RRS_IDLE;
                end
            end
            RRS_RUN: begin
                if (!stop_s || core_req.local_stop || core_req.run_done) begin
                    next_state.mode = RRS_IDLE;
                    next_state.stop_evt = 1'b1;
                    next_state.relay = 1'b0;
                    next_state.relay_cnt = '0;
                    next_state.drive_cnt = '0;
                end
            end
            default: begin
                next_state.mode = RRS_IDLE;
            end
        endcase
        if (go && !(state.mode == RRS_PREP && !stop_s)) begin
            next_state.mode = RRS_RUN;
            next_state.start_evt = 1'b1;
            next_state.relay = 1'b1;
            next_state.relay_cnt = CNT_W'(RELAY_CYC - 1);
            if (own_start) begin
                next_state.drive_cnt = CNT_W'(START_OUT_CYC);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    always_comb begin
        // Outputs only ever sink; the pull-up makes the high level
        pins.prepare.o = 1'b0;
        pins.prepare.oe = 1'b0;
        pins.stop.o = 1'b0;
        pins.stop.oe = 1'b0;
        pins.start.o = 1'b0;
        pins.start.oe = state.drive_cnt != '0;
        pins.ready.o = 1'b0;
        // Busy while running, preparing or not ready in the core
        pins.ready.oe = !core_req.sys_ready || state.mode != RRS_IDLE;
        pins.relay_closed = state.relay;
    end

    // One driver for the whole indication word
    always_comb begin
        ind.mode = state.mode;
        ind.prep_evt = state.prep_evt;
        ind.start_evt = state.start_evt;
        ind.stop_evt = state.stop_evt;
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_never_drive_high: assert property (@(posedge clk) disable iff (rst)
        !pins.start.o && !pins.ready.o && !pins.prepare.o && !pins.stop.o)
        else $error("line driven high");
    chk_prep_enters: assert property (@(posedge clk) disable iff (rst)
        (state.mode == RRS_IDLE && !prep_s && !go) |=> state.mode == RRS_PREP)
        else $error("prepare not taken");
    chk_prep_local: assert property (@(posedge clk) disable iff (rst)
        (state.mode == RRS_IDLE && core_req.local_prepare && !go) |=> state.mode == RRS_PREP)
        else $error("core prepare not taken");
    chk_prep_evt_once: assert property (@(posedge clk) disable iff (rst)
        state.prep_evt |=> !state.prep_evt)
        else $error("prepare event too long");
    chk_ready_released: assert property (@(posedge clk) disable iff (rst)
        (state.mode == RRS_IDLE && core_req.sys_ready) |-> !pins.ready.oe)
        else $error("ready held low while ready");
    chk_no_restart_run: assert property (@(posedge clk) disable iff (rst)
        state.mode == RRS_RUN |=> !state.start_evt)
        else $error("start taken during run");
    chk_ready_low_busy: assert property (@(posedge clk) disable iff (rst)
        state.mode == RRS_RUN |-> pins.ready.oe)
        else $error("ready released during run");
    chk_short_start_ignored: assert property (@(posedge clk) disable iff (rst)
        ext_start |-> state.low_run >= CNT_W'(START_MIN_CYC - 1))
        else $error("start taken too early");
    chk_relay_holds: assert property (@(posedge clk) disable iff (rst)
        (state.relay && state.relay_cnt != '0 && state.mode == RRS_RUN && stop_s
            && !core_req.local_stop && !core_req.run_done) |=> state.relay)
        else $error("relay opened before time");
    chk_relay_opens: assert property (@(posedge clk) disable iff (rst)
        $fell(state.relay) && state.mode == RRS_RUN |-> state.relay_cnt == '0)
        else $error("relay opened early");
    chk_relay_on_start: assert property (@(posedge clk) disable iff (rst)
        $rose(state.start_evt) |-> state.relay)
        else $error("relay not closed on start");
    chk_stop_ends_run: assert property (@(posedge clk) disable iff (rst)
        (state.mode == RRS_RUN && !stop_s) |=> state.mode == RRS_IDLE && !state.relay)
        else $error("stop ignored");
    chk_stop_drops_drive: assert property (@(posedge clk) disable iff (rst)
        (state.mode == RRS_RUN && (!stop_s || core_req.local_stop || core_req.run_done))
            |=> state.mode == RRS_IDLE && !pins.start.oe && state.stop_evt)
        else $error("run not ended");
    chk_own_start_drive: assert property (@(posedge clk) disable iff (rst)
        (own_start && stop_s) |=> pins.start.oe [*8])
        else $error("start not driven");
    cov_ext_start: cover property (@(posedge clk) disable iff (rst) ext_start);
    cov_stop_run: cover property (@(posedge clk) disable iff (rst) state.stop_evt);
    cov_own_start: cover property (@(posedge clk) disable iff (rst) own_start && stop_s);
    cov_prep_stop: cover property (@(posedge clk) disable iff (rst)
        state.mode == RRS_PREP ##1 state.mode == RRS_IDLE);
    cov_prep_run: cover property (@(posedge clk) disable iff (rst)
        state.mode == RRS_PREP ##1 state.mode == RRS_RUN);
endmodule
`default_nettype wire

// ==== rrs_pkg.sv ====
// Package with constants, types and the state encoding of the run-sync port
`default_nettype none
package rrs_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    // Least start low time in microseconds, converted with whole cycles per microsecond
    localparam int unsigned START_MIN_US = 500;
    localparam int unsigned START_MIN_CYC = (START_MIN_US * (CLK_HZ / 1_000_000));
    // Start contact closure time in milliseconds
    localparam int unsigned RELAY_MS = 120;
    localparam int unsigned RELAY_CYC_DEF = RELAY_MS * (CLK_HZ / 1000);
    // Length of the start pulse the port drives itself, in cycles
    localparam int unsigned START_OUT_CYC = START_MIN_CYC + 1;
    localparam int unsigned CNT_W = 21;

    typedef enum logic [1:0] {RRS_IDLE, RRS_PREP, RRS_RUN} rrs_mode_t;

    // One open-drain line at the pins
    typedef struct packed {
        logic o;
        logic oe;
    } rrs_od_t;

    // Pins driven by the port
    typedef struct packed {
        rrs_od_t prepare;
        rrs_od_t start;
        rrs_od_t ready;
        rrs_od_t stop;
        logic relay_closed;
    } rrs_pins_out_t;

    // Requests from the instrument core
    typedef struct packed {
        logic sys_ready;
        logic local_prepare;
        logic local_start;
        logic local_stop;
        logic run_done;
    } rrs_core_req_t;

    // Indications to the instrument core
    typedef struct packed {
        rrs_mode_t mode;
        logic prep_evt;
        logic start_evt;
        logic stop_evt;
    } rrs_core_ind_t;
endpackage
`default_nettype wire

// ==== rrs_sync.sv ====
// Two flip-flop synchroniser for one line, reset to the released (high) level
`default_nettype none
module rrs_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    import rrs_pkg::*;

    typedef struct packed {
        logic meta;
        logic q;
    } rrs_sync_state_t;

    rrs_sync_state_t state;
    rrs_sync_state_t next_state;

    always_comb begin
        next_state.meta = d;
        next_state.q = state.meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= 2'h3;
        end else begin
            state <= next_state;
        end
    end

    assign q = state.q;
endmodule
`default_nettype wire

// ==== rrs_peer.sv ====
// Model of another instrument sharing the run-sync lines
`default_nettype none
module rrs_peer
    import rrs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pull_prep,
    input wire logic pull_stop,
    input wire logic go,
    input wire logic [15:0] len,
    input wire rrs_pkg::rrs_pins_out_t pins,
    output logic prepare_ln,
    output logic start_ln,
    output logic ready_ln,
    output logic stop_ln
);
    import rrs_pkg::*;
    logic [15:0] cnt;
    // Outside start held low for exactly len cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 16'h0000;
        end else if (go) begin
            cnt <= len;
        end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
        end
    end
    // Wired-AND with pull-up: nobody drives high; stop stays open unless asked
    assign prepare_ln = !(pull_prep || pins.prepare.oe);
    assign start_ln = !((cnt != 16'h0000) || pins.start.oe);
    assign ready_ln = !pins.ready.oe;
    assign stop_ln = !(pull_stop || pins.stop.oe);
endmodule
`default_nettype wire

// ==== rrs_port_test.sv ====
// Self-checking bench of the run-sync port
`default_nettype none
module rrs_port_test;
    import rrs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned RC = 50;
    logic clk, rst, pp, ps, go, pl, sl, rl, tl;
    logic [15:0] len;
    rrs_core_req_t req;
    rrs_pins_out_t pins;
    rrs_core_ind_t ind;
    int failures = 0;
    int n_compared = 0;
    int n;
    // Short relay time keeps the run brief
    rrs_port #(.RELAY_CYC(RC)) dut (.clk(clk), .rst(rst), .prepare_in(pl), .start_in(sl),
        .ready_in(rl), .stop_in(tl), .core_req(req), .pins(pins), .ind(ind));
    rrs_peer peer (.clk(clk), .rst(rst), .pull_prep(pp), .pull_stop(ps), .go(go), .len(len),
        .pins(pins), .prepare_ln(pl), .start_ln(sl), .ready_ln(rl), .stop_ln(tl));
    initial begin
        clk = 1'b0;
        forever #50 clk = !clk;
    end
    // ********************
    // Helpers
    // ********************
    task automatic conclude();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic bad(input string m);
        $display("mismatch at %0t: %s", $time, m);
        failures++;
    endtask
    task automatic chk_bit(input logic g, input logic e);
        n_compared++;
        if (g !== e) bad("bit");
    endtask
    task automatic chk_mode(input rrs_mode_t g, input rrs_mode_t e);
        n_compared++;
        if (g !== e) bad("mode");
    endtask
    task automatic chk_num(input int g, input int e);
        n_compared++;
        if (g != e) bad("count");
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return ind.start_evt;
            1: return pins.relay_closed;
            2: return ind.prep_evt;
            3: return ind.stop_evt;
            default: return pins.start.oe;
        endcase
    endfunction
    task automatic wait_sig(input int s, input int bound);
        int i;
        i = 0;
        while (sig(s) !== 1'b1) begin
            @(negedge clk);
            i++;
            if (i > bound) begin
                bad("wait ran out");
                conclude();
            end
        end
    endtask
    task automatic count_high(input int s, output int k);
        k = 0;
        while (sig(s) === 1'b1 && k < 6000) begin
            k++;
            @(negedge clk);
        end
    endtask
    task automatic pulse_go(input logic [15:0] l);
        @(posedge clk);
        go <= 1'b1;
        len <= l;
        @(posedge clk);
        go <= 1'b0;
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_reset();
        @(negedge clk);
        chk_bit(pins.ready.oe, 1'b1);
        chk_bit(pins.start.oe | pins.start.o | pins.ready.o, 1'b0);
        chk_bit(pins.relay_closed, 1'b0);
        chk_mode(ind.mode, RRS_IDLE);
    endtask
    task automatic t_prepare();
        @(posedge clk);
        pp <= 1'b1;
        wait_sig(2, 10);
        @(negedge clk);
        chk_mode(ind.mode, RRS_PREP);
        @(posedge clk);
        pp <= 1'b0;
        // Let the released line clear the synchroniser, or idle re-enters preparation
        repeat (3) @(posedge clk);
        req.local_stop <= 1'b1;
        @(posedge clk);
        req.local_stop <= 1'b0;
        repeat (2) @(negedge clk);
        chk_mode(ind.mode, RRS_IDLE);
        @(posedge clk);
        req.local_prepare <= 1'b1;
        req.sys_ready <= 1'b1;
        @(posedge clk);
        req.local_prepare <= 1'b0;
        @(negedge clk);
        chk_bit(ind.prep_evt, 1'b1);
        chk_mode(ind.mode, RRS_PREP);
        chk_bit(pins.ready.oe, 1'b1);
    endtask
    task automatic t_ext_start();
        pulse_go(16'(START_MIN_CYC - 1));
        n = 0;
        repeat (5100) begin
            @(negedge clk);
            if (ind.start_evt === 1'b1) n++;
        end
        chk_num(n, 0);
        chk_mode(ind.mode, RRS_PREP);
        pulse_go(16'(START_MIN_CYC));
        wait_sig(0, 5100);
        @(negedge clk);
        chk_mode(ind.mode, RRS_RUN);
        chk_bit(pins.ready.oe, 1'b1);
        count_high(1, n);
        chk_num(n + 1, RC);
        @(posedge clk);
        ps <= 1'b1;
        wait_sig(3, 10);
        @(negedge clk);
        chk_mode(ind.mode, RRS_IDLE);
        chk_bit(pins.ready.oe, 1'b0);
        @(posedge clk);
        ps <= 1'b0;
    endtask
    task automatic t_local_start();
        @(posedge clk);
        req.sys_ready <= 1'b1;
        repeat (2) @(negedge clk);
        chk_bit(rl, 1'b1);
        @(posedge clk);
        req.local_start <= 1'b1;
        @(posedge clk);
        req.local_start <= 1'b0;
        wait_sig(4, 5);
        chk_bit(sl, 1'b0);
        chk_bit(pins.relay_closed, 1'b1);
        count_high(4, n);
        chk_num(n, START_OUT_CYC);
        chk_mode(ind.mode, RRS_RUN);
        @(posedge clk);
        req.run_done <= 1'b1;
        @(posedge clk);
        req.run_done <= 1'b0;
        @(negedge clk);
        chk_mode(ind.mode, RRS_IDLE);
        chk_bit(pins.start.oe, 1'b0);
    endtask
    initial begin
        rst = 1'b1;
        pp = 1'b0;
        ps = 1'b0;
        go = 1'b0;
        len = 16'h0000;
        req = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_prepare();
        t_ext_start();
        t_local_start();
        conclude();
    end
endmodule
`default_nettype wire
